/* File: bench/afp_link_chk.sv */
`timescale 1ns/1ps
`include "afp_params.svh"
module afp_link_chk #(
    parameter int RESET_GAP_CYC = `AFP_RESET_GAP_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic reset_n,
    input wire logic osc_ext_clk,
    input wire logic fault_shutdown_n,
    input wire logic fault_shutdown_n_oe,
    input wire logic thermal_warning_first_n,
    input wire logic thermal_warning_first_n_oe,
    input wire logic thermal_warning_second_n,
    input wire logic thermal_warning_second_n_oe
);
    int gap_ff;
    int low_ff;
    logic rn_ff;
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // High time counted from last low; stricter than from the fall
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gap_ff <= 0;
        end else if (!fault_shutdown_n) begin
            gap_ff <= 0;
        end else if (gap_ff < RESET_GAP_CYC) begin
            gap_ff <= gap_ff + 1;
        end
    end
    // Power-up low on reset_n is not counted, only a real fall
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rn_ff <= 1'b0;
            low_ff <= 0;
        end else begin
            rn_ff <= reset_n;
            if (reset_n) begin
                low_ff <= 0;
            end else if ((rn_ff || low_ff != 0) && low_ff < 15) begin
                low_ff <= low_ff + 1;
            end
        end
    end
    a_sd_open_drain: assert property (
        fault_shutdown_n_oe |-> !fault_shutdown_n)
        else $error("shutdown flag driven high");
    a_w1_open_drain: assert property (
        thermal_warning_first_n_oe |-> !thermal_warning_first_n)
        else $error("first warning driven high");
    a_w2_open_drain: assert property (
        thermal_warning_second_n_oe |-> !thermal_warning_second_n)
        else $error("second warning driven high");
    a_warn_order: assert property (
        thermal_warning_second_n_oe |-> thermal_warning_first_n_oe)
        else $error("second warning without first");
    a_reset_gap: assert property (
        $rose(reset_n) |-> gap_ff >= RESET_GAP_CYC)
        else $error("reset raised too soon after flag");
    a_rise_flag_high: assert property (
        $rose(reset_n) |-> $past(fault_shutdown_n))
        else $error("reset raised while flag low");
    a_hide_fault: assert property (low_ff >= 7 |-> fault_shutdown_n)
        else $error("shutdown flag low while reset held");
    a_osc_div: assert property (
        $changed(osc_ext_clk) |=> $stable(osc_ext_clk))
        else $error("external clock toggles too fast");
endmodule : afp_link_chk

/* File: bench/amp_fault_protection_control_tb.sv */
`timescale 1ns/1ps
module amp_fault_protection_control_tb;
    import afp_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    afp_cfg_t cfg = AFP_CFG_BRIDGE;
    logic uv = 1'b0, ol = 1'b0, oc = 1'b0, nc = 1'b0, trim = 1'b0;
    logic t1 = 1'b0, t2 = 1'b0, t3 = 1'b0, rq = 1'b0, xen = 1'b0;
    logic [3:0] bs = 4'h0, le = 4'h0, sg = 4'h2, ss = 4'h0;
    logic [3:0] hb, pd;
    logic osc_en, sd_seen, a_ok, w_seen;
    int miscompares = 0;
    int tests_run = 0;
    afp_link_if link ();
    wire sd = link.fault_shutdown_n;
    always #25 clk = ~clk;
    afp_device #(.LARGE_PKG(1'b1), .SHORT_STEP_CYC(16)) u_afp_device (
        .clk(clk), .rst_n(rst_n), .link(link), .out_cfg(cfg),
        .supply_undervolt(uv), .bootstrap_undervolt(bs), .local_error(le),
        .overload_protect(ol), .overcurrent_detect(oc),
        .temp_over_100(t1), .temp_over_125(t2), .temp_over_155(t3),
        .short_to_gnd(sg), .short_to_sup(ss), .near_clip(nc),
        .switching_freq_trim_at_reg(trim), .hb_enable(hb),
        .hb_pulldown(pd), .osc_internal_en(osc_en));
    afp_ctrl #(.RESET_GAP_CYC(20), .CLK_DIV(4)) u_afp_ctrl (
        .clk(clk), .rst_n(rst_n), .link(link), .reset_req(rq),
        .ext_clk_en(xen), .shutdown_seen(sd_seen), .warning_seen(w_seen),
        .audio_ok(a_ok));
    afp_link_chk #(.RESET_GAP_CYC(20)) u_afp_link_chk (
        .clk(clk), .rst_n(rst_n), .reset_n(link.reset_n),
        .osc_ext_clk(link.osc_ext_clk), .fault_shutdown_n(sd),
        .fault_shutdown_n_oe(link.fault_shutdown_n_oe),
        .thermal_warning_first_n(link.thermal_warning_first_n),
        .thermal_warning_first_n_oe(link.thermal_warning_first_n_oe),
        .thermal_warning_second_n(link.thermal_warning_second_n),
        .thermal_warning_second_n_oe(link.thermal_warning_second_n_oe));
    task automatic chk(string nm, logic [3:0] seen, logic [3:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic stop_test();
        if (miscompares == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test
    // Settle past the five-edge input to output latency
    task automatic cyc(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    task automatic wait_run();
        for (int i = 0; i < 400 && !(hb === 4'hf && link.ready === 1'b1);
                i++) begin
            cyc(1);
        end
        chk("run", hb, 4'hf);
    endtask : wait_run
    task automatic rpulse(logic [3:0] pde);
        @(posedge clk) rq <= 1'b1;
        cyc(12);
        chk("rst_hb", hb, 4'h0);
        chk("rst_pd", pd, pde);
        chk("rst_sd", sd, 1'b1);
        @(posedge clk) rq <= 1'b0;
        wait_run();
    endtask : rpulse
    task automatic t_start();
        cyc(8);
        chk("chk_sd", sd, 1'b0);
        chk("chk_pd", pd, 4'h0);
        cyc(40);
        chk("gnd_hb", hb, 4'h0);
        @(posedge clk);
        sg <= 4'h0;
        ss <= 4'h8;
        cyc(60);
        chk("sup_hb", hb, 4'h0);
        @(posedge clk) ss <= 4'h0;
        wait_run();
        chk("pass_sd", sd, 1'b1);
    endtask : t_start
    // Late short must not stop switching, nor a reset rerun the check
    task automatic t_late();
        @(posedge clk) sg <= 4'hf;
        cyc(40);
        chk("late_hb", hb, 4'hf);
        rpulse(4'hf);
        @(posedge clk) sg <= 4'h0;
    endtask : t_late
    task automatic t_map();
        logic [3:0] e;
        for (int k = 0; k < 3; k++) begin
            @(posedge clk) cfg <= afp_cfg_t'(k[1:0]);
            for (int i = 0; i < 4; i++) begin
                e = (k == 1) ? 4'h0 : ((i < 2) ? 4'hc : 4'h3);
                @(posedge clk) le <= 4'h1 << i;
                cyc(8);
                chk("loc_hb", hb, e);
                chk("loc_sd", sd, 1'b0);
                @(posedge clk);
                le <= 4'h0;
                bs <= 4'h1 << i;
                cyc(8);
                chk("bst_hb", hb, ~(4'h1 << i));
                @(posedge clk) bs <= 4'h0;
                cyc(8);
                chk("back_hb", hb, 4'hf);
            end
        end
        @(posedge clk) cfg <= AFP_CFG_BRIDGE;
    endtask : t_map
    task automatic t_auto();
        @(posedge clk) uv <= 1'b1;
        cyc(8);
        chk("uv_hb", hb, 4'h0);
        chk("uv_sd", sd, 1'b0);
        @(posedge clk) uv <= 1'b0;
        wait_run();
        @(posedge clk) oc <= 1'b1;
        cyc(8);
        chk("oc_rdy", link.ready, 1'b0);
        chk("oc_hb", hb, 4'h0);
        @(posedge clk) oc <= 1'b0;
        wait_run();
        cyc(8);
        chk("oc_aok", a_ok, 1'b1);
    endtask : t_auto
    task automatic t_olp();
        @(posedge clk) ol <= 1'b1;
        cyc(8);
        @(posedge clk) ol <= 1'b0;
        cyc(20);
        chk("olp_hb", hb, 4'h0);
        chk("olp_seen", sd_seen, 1'b1);
        rpulse(4'hf);
        chk("olp_clr", hb, 4'hf);
    endtask : t_olp
    task automatic t_ote();
        @(posedge clk) t1 <= 1'b1;
        cyc(8);
        chk("w1", link.thermal_warning_first_n, 1'b0);
        chk("w2", link.thermal_warning_second_n, 1'b1);
        @(posedge clk) t2 <= 1'b1;
        cyc(8);
        chk("w2b", link.thermal_warning_second_n, 1'b0);
        chk("w_sd", sd, 1'b1);
        chk("w_seen", w_seen, 1'b1);
        @(posedge clk) t3 <= 1'b1;
        cyc(8);
        @(posedge clk);
        t1 <= 1'b0;
        t2 <= 1'b0;
        t3 <= 1'b0;
        cyc(20);
        chk("ote_hb", hb, 4'h0);
        chk("ote_sd", sd, 1'b0);
        rpulse(4'hf);
        chk("w1_off", link.thermal_warning_first_n, 1'b1);
        chk("w_seen_off", w_seen, 1'b0);
    endtask : t_ote
    task automatic t_misc();
        int n;
        logic b;
        @(posedge clk);
        nc <= 1'b1;
        trim <= 1'b1;
        xen <= 1'b1;
        cyc(8);
        chk("clip", link.clip, 1'b1);
        chk("osc_int", osc_en, 1'b0);
        n = 0;
        for (int i = 0; i < 16; i++) begin
            b = link.osc_ext_clk;
            cyc(1);
            n += (link.osc_ext_clk !== b);
        end
        chk("osc_tog", n > 0, 1'b1);
        @(posedge clk);
        nc <= 1'b0;
        trim <= 1'b0;
        xen <= 1'b0;
        cyc(8);
        chk("clip_off", link.clip, 1'b0);
    endtask : t_misc
    // Second power-up in single-ended with a short and a stale overload
    task automatic t_se();
        @(posedge clk) ol <= 1'b1;
        cyc(8);
        @(posedge clk);
        ol <= 1'b0;
        rst_n <= 1'b0;
        cfg <= AFP_CFG_SINGLE;
        sg <= 4'hf;
        cyc(10);
        @(posedge clk) rst_n <= 1'b1;
        wait_run();
        chk("se_hb", hb, 4'hf);
        rpulse(4'h0);
    endtask : t_se
    initial begin
        cyc(10);
        chk("por_hb", hb, 4'h0);
        chk("por_osc", osc_en, 1'b1);
        @(posedge clk) rst_n <= 1'b1;
        t_start();
        t_late();
        t_map();
        t_auto();
        t_olp();
        t_ote();
        t_misc();
        t_se();
        stop_test();
    end
    // Whole run is about a thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        stop_test();
    end
endmodule : amp_fault_protection_control_tb

/* File: src/afp_ctrl.sv */
`timescale 1ns/1ps
`include "afp_params.svh"
module afp_ctrl #(
    parameter int RESET_GAP_CYC = `AFP_RESET_GAP_CYC,
    parameter int CLK_DIV = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    afp_link_if.ctrl link,
    input wire logic reset_req,
    input wire logic ext_clk_en,
    output logic shutdown_seen,
    output logic warning_seen,
    output logic audio_ok
);
    import afp_pkg::*;
    initial begin
        if (RESET_GAP_CYC < 1 || RESET_GAP_CYC > 16777215 ||
                CLK_DIV < 2 || CLK_DIV > 512) begin
            $error("controller parameters out of range");
        end
    end
    logic [2:0] sd_s_ff, w1_s_ff, w2_s_ff, rdy_s_ff;
    logic sd_ff, rdy_ff;
    logic [23:0] gap_ff;
    logic [7:0] div_ff;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sd_s_ff <= 3'h7;
            w1_s_ff <= 3'h7;
            w2_s_ff <= 3'h7;
            rdy_s_ff <= 3'h0;
            sd_ff <= 1'b1;
            rdy_ff <= 1'b0;
        end else begin
            sd_s_ff <= {sd_s_ff[1:0], link.fault_shutdown_n};
            w1_s_ff <= {w1_s_ff[1:0], link.thermal_warning_first_n};
            w2_s_ff <= {w2_s_ff[1:0], link.thermal_warning_second_n};
            rdy_s_ff <= {rdy_s_ff[1:0], link.ready};
            if (sd_s_ff[1] == sd_s_ff[2]) begin
                sd_ff <= sd_s_ff[2];
            end
            if (rdy_s_ff[1] == rdy_s_ff[2]) begin
                rdy_ff <= rdy_s_ff[2];
            end
        end
    end
    // reset held low at least gap after flag fell
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gap_ff <= 24'h000000;
            link.reset_n <= 1'b0;
        end else begin
            // Restart on every low sample, so a fall always waits
            if (!sd_ff || !sd_s_ff[2]) begin
                gap_ff <= 24'h000000;
            end else if (gap_ff != 24'(RESET_GAP_CYC)) begin
                gap_ff <= gap_ff + 24'h000001;
            end
            if (reset_req) begin
                link.reset_n <= 1'b0;
            end else if (gap_ff == 24'(RESET_GAP_CYC)) begin
                link.reset_n <= 1'b1;
            end
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_ff <= 8'h00;
            link.osc_ext_clk <= 1'b0;
        end else if (!ext_clk_en) begin
            div_ff <= 8'h00;
            link.osc_ext_clk <= 1'b0;
        end else if (div_ff == 8'(CLK_DIV / 2 - 1)) begin
            div_ff <= 8'h00;
            link.osc_ext_clk <= !link.osc_ext_clk;
        end else begin
            div_ff <= div_ff + 8'h01;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shutdown_seen <= 1'b0;
            warning_seen <= 1'b0;
            audio_ok <= 1'b0;
        end else begin
            shutdown_seen <= !sd_ff;
            warning_seen <= !(w1_s_ff[2] && w2_s_ff[2]);
            audio_ok <= rdy_ff;
        end
    end
endmodule : afp_ctrl

/* File: src/afp_device.sv */
// What this block does
// - Any fault: Hi-Z stage, shutdown flag low
// - Non-latched faults recover on their own
// - Local errors disable pair, parallel disables all
// - Bootstrap undervoltage disables own half-bridge
// - Short check only at power-up
// - Found short holds Hi-Z until gone
// - Check ground shorts, then supply shorts
// - During check: flag low, reset ignored
// - Short check skipped in single-ended
// - Large package: warnings 100, 125; shutdown 155
// - Small package: warning 125; shutdown 155
// - Thermal shutdown latched until reset
// - Power-on reset clears overload, holds inactive
// - Undervoltage: all Hi-Z, flag low
// - Reset low: all half-bridges Hi-Z
// - Reset low: pulldown unless single-ended or during check
// - Reset low forces shutdown flag high, except during check
// - Reset rising edge leaves overload fault
// - Controller waits 4 ms before raising reset
// - Ready falls on overcurrent
// - Clip shown when near clipping
// - Trim tied to regulator selects external clock
// - Flags are active-low open drain
`timescale 1ns/1ps
`include "afp_params.svh"
module afp_device #(
    parameter bit LARGE_PKG = 1'b1,
    parameter int SHORT_STEP_CYC = `AFP_SHORT_STEP_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    afp_link_if.device link,
    input wire afp_pkg::afp_cfg_t out_cfg,
    input wire logic supply_undervolt,
    input wire logic [3:0] bootstrap_undervolt,
    input wire logic [3:0] local_error,
    input wire logic overload_protect,
    input wire logic overcurrent_detect,
    input wire logic temp_over_100,
    input wire logic temp_over_125,
    input wire logic temp_over_155,
    input wire logic [3:0] short_to_gnd,
    input wire logic [3:0] short_to_sup,
    input wire logic near_clip,
    input wire logic switching_freq_trim_at_reg,
    output logic [3:0] hb_enable,
    output logic [3:0] hb_pulldown,
    output logic osc_internal_en
);
    import afp_pkg::*;
    localparam int NIN = 25;
    initial begin
        if (SHORT_STEP_CYC < 1 || SHORT_STEP_CYC > 65535) begin
            $error("short step count out of range");
        end
    end
    logic [NIN-1:0] raw;
    logic [NIN-1:0] s1_ff, s2_ff, s3_ff, clean_ff;
    assign raw = {link.reset_n, switching_freq_trim_at_reg, near_clip,
        short_to_sup, short_to_gnd, temp_over_155, temp_over_125,
        temp_over_100, overcurrent_detect, overload_protect, local_error,
        bootstrap_undervolt, supply_undervolt};
    // sync chain
    // Third stage confirms a change before it counts
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            // Undervoltage assumed until seen, so power-up waits
            s1_ff <= `AFP_SYNC_RST;
            s2_ff <= `AFP_SYNC_RST;
            s3_ff <= `AFP_SYNC_RST;
            clean_ff <= `AFP_SYNC_RST;
        end else begin
            s1_ff <= raw;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            for (int i = 0; i < NIN; i++) begin
                if (s2_ff[i] == s3_ff[i]) begin
                    clean_ff[i] <= s3_ff[i];
                end
            end
        end
    end
    logic uv, oc, ol, t100, t125, t155, clipc, slave, rstn;
    logic [3:0] bsu, lerr, sg, ss;
    assign uv = clean_ff[0];
    assign bsu = clean_ff[4:1];
    assign lerr = clean_ff[8:5];
    assign ol = clean_ff[9];
    assign oc = clean_ff[10];
    assign t100 = clean_ff[11];
    assign t125 = clean_ff[12];
    assign t155 = clean_ff[13];
    assign sg = clean_ff[17:14];
    assign ss = clean_ff[21:18];
    assign clipc = clean_ff[22];
    assign slave = clean_ff[23];
    assign rstn = clean_ff[24];

    function automatic logic [3:0] group_off(input logic [3:0] e,
            input afp_cfg_t c);
        logic [3:0] r;
        r = 4'h0;
        if (c == AFP_CFG_PARALLEL) begin
            r = (|e) ? 4'hf : 4'h0;
        end else begin
            r[1:0] = (|e[1:0]) ? 2'h3 : 2'h0;
            r[3:2] = (|e[3:2]) ? 2'h3 : 2'h0;
        end
        return r;
    endfunction : group_off

    afp_state_t state_ff;
    logic rst_prev_ff, ote_ff;
    logic [15:0] step_cnt_ff;
    logic rise;
    assign rise = rstn && !rst_prev_ff;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_prev_ff <= 1'b0;
        end else begin
            rst_prev_ff <= rstn;
        end
    end

    // check sequencer, launched only from power-up state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= AFP_ST_POWERUP;
            step_cnt_ff <= 16'h0000;
        end else begin
            unique case (state_ff)
                AFP_ST_POWERUP: begin
                    if (!uv) begin
                        state_ff <= (out_cfg == AFP_CFG_SINGLE) ?
                            AFP_ST_RUN : AFP_ST_SHORT_GND;
                    end
                    step_cnt_ff <= 16'h0000;
                end
                AFP_ST_SHORT_GND: begin
                    // ground step first; hold while shorted
                    if (|sg) begin
                        step_cnt_ff <= 16'h0000;
                    end else if (step_cnt_ff == 16'(SHORT_STEP_CYC - 1)) begin
                        step_cnt_ff <= 16'h0000;
                        state_ff <= AFP_ST_SHORT_SUP;
                    end else begin
                        step_cnt_ff <= step_cnt_ff + 16'h0001;
                    end
                end
                AFP_ST_SHORT_SUP: begin
                    if (|ss) begin
                        step_cnt_ff <= 16'h0000;
                    end else if (step_cnt_ff == 16'(SHORT_STEP_CYC - 1)) begin
                        step_cnt_ff <= 16'h0000;
                        state_ff <= AFP_ST_RUN;
                    end else begin
                        step_cnt_ff <= step_cnt_ff + 16'h0001;
                    end
                end
                AFP_ST_RUN: begin
                    // overload is the latched one here
                    if (ol && rstn) begin
                        state_ff <= AFP_ST_OVERLOAD;
                    end
                end
                AFP_ST_OVERLOAD: begin
                    if (rise) begin
                        state_ff <= AFP_ST_RUN;
                    end
                end
                default: begin
                    state_ff <= AFP_ST_POWERUP;
                end
            endcase
        end
    end

    logic checking;
    assign checking = (state_ff == AFP_ST_SHORT_GND) ||
        (state_ff == AFP_ST_SHORT_SUP);

    // latched thermal shutdown, cleared by reset low
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ote_ff <= 1'b0;
        end else if (t155) begin
            ote_ff <= 1'b1;
        end else if (!rstn && !checking) begin
            ote_ff <= 1'b0;
        end
    end

    logic hold_rst;
    assign hold_rst = !rstn && !checking;
    logic fault;
    // undervoltage counts as fault; oc follows input, ote_ff and overload state latch
    assign fault = uv || ote_ff || checking || oc ||
        (state_ff == AFP_ST_POWERUP) || (state_ff == AFP_ST_OVERLOAD);

    logic [3:0] nxt_en;
    always_comb begin
        nxt_en = 4'hf;
        if (fault || hold_rst) begin
            nxt_en = 4'h0;
        end else begin
            nxt_en = nxt_en & ~group_off(lerr, out_cfg);
            nxt_en = nxt_en & ~bsu;
        end
    end

    logic sd_low;
    // reset low hides faults; check keeps flag low
    assign sd_low = checking || (rstn && (fault || (|lerr) || (|bsu)));

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hb_enable <= 4'h0;
            hb_pulldown <= 4'h0;
            osc_internal_en <= 1'b1;
        end else begin
            hb_enable <= nxt_en;
            hb_pulldown <= (hold_rst && out_cfg != AFP_CFG_SINGLE) ?
                4'hf : 4'h0;
            osc_internal_en <= !slave;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            link.fault_shutdown_n_o <= 1'b0;
            link.fault_shutdown_n_oe <= 1'b0;
            link.thermal_warning_first_n_o <= 1'b0;
            link.thermal_warning_first_n_oe <= 1'b0;
            link.thermal_warning_second_n_o <= 1'b0;
            link.thermal_warning_second_n_oe <= 1'b0;
            link.ready <= 1'b0;
            link.clip <= 1'b0;
        end else begin
            link.fault_shutdown_n_o <= 1'b0;
            link.fault_shutdown_n_oe <= sd_low;
            link.thermal_warning_first_n_o <= 1'b0;
            link.thermal_warning_first_n_oe <= LARGE_PKG ? t100 : t125;
            link.thermal_warning_second_n_o <= 1'b0;
            link.thermal_warning_second_n_oe <= t125;
            link.ready <= !sd_low && !oc;
            link.clip <= clipc;
        end
    end
endmodule : afp_device

/* File: src/afp_link_if.sv */
`timescale 1ns/1ps
interface afp_link_if;
    logic reset_n;
    logic fault_shutdown_n_o;
    logic fault_shutdown_n_oe;
    logic thermal_warning_first_n_o;
    logic thermal_warning_first_n_oe;
    logic thermal_warning_second_n_o;
    logic thermal_warning_second_n_oe;
    logic ready;
    logic clip;
    logic osc_ext_clk;
    // Open-drain wires with pullups
    logic fault_shutdown_n;
    logic thermal_warning_first_n;
    logic thermal_warning_second_n;
    assign fault_shutdown_n = fault_shutdown_n_oe ? fault_shutdown_n_o : 1'b1;
    assign thermal_warning_first_n =
        thermal_warning_first_n_oe ? thermal_warning_first_n_o : 1'b1;
    assign thermal_warning_second_n =
        thermal_warning_second_n_oe ? thermal_warning_second_n_o : 1'b1;
    modport device (
        input reset_n, osc_ext_clk,
        output fault_shutdown_n_o, fault_shutdown_n_oe,
        output thermal_warning_first_n_o, thermal_warning_first_n_oe,
        output thermal_warning_second_n_o, thermal_warning_second_n_oe,
        output ready, clip
    );
    modport ctrl (
        output reset_n, osc_ext_clk,
        input fault_shutdown_n, thermal_warning_first_n,
        input thermal_warning_second_n, ready, clip
    );
endinterface : afp_link_if

/* File: src/afp_params.svh */
`ifndef AFP_PARAMS_SVH
`define AFP_PARAMS_SVH
// Clock period in ns
`define AFP_CLK_NS 50
// Least reset-low spacing after shutdown flag falls, in ms
`define AFP_RESET_GAP_MS 4
`define AFP_RESET_GAP_CYC ((`AFP_RESET_GAP_MS * 1000000 + `AFP_CLK_NS - 1) / `AFP_CLK_NS)
// Cycles each short-check step must see a clean level
`define AFP_SHORT_STEP_CYC 16
// Half-bridge index positions
`define AFP_HB_A 0
`define AFP_HB_B 1
`define AFP_HB_C 2
`define AFP_HB_D 3
// Synchroniser reset: supply undervoltage bit set
`define AFP_SYNC_RST 25'h0000001
`endif

/* File: src/afp_pkg.sv */
package afp_pkg;
    typedef enum logic [1:0] {
        AFP_CFG_BRIDGE = 2'b00,
        AFP_CFG_PARALLEL = 2'b01,
        AFP_CFG_SINGLE = 2'b10
    } afp_cfg_t;
    typedef enum logic [2:0] {
        AFP_ST_POWERUP = 3'b000,
        AFP_ST_SHORT_GND = 3'b001,
        AFP_ST_SHORT_SUP = 3'b010,
        AFP_ST_RUN = 3'b011,
        AFP_ST_OVERLOAD = 3'b100
    } afp_state_t;
endpackage : afp_pkg
